//--- verilog/uub_pkg.sv
// Purpose: Shared constants and carriers for the bridge register bank
// Assumes: Vendor control requests arrive already decoded into setup fields
// Notes: Register words are 16 bits; reserved bits are masked on write and read
package uub_pkg;

  localparam logic [7:0] REQ_TYPE_REG_WRITE = 8'h41;
  localparam logic [7:0] REQ_TYPE_REG_READ = 8'hC1;
  localparam logic [7:0] REQ_TYPE_DEV_WRITE = 8'h40;
  localparam logic [7:0] REQ_TYPE_DEV_READ = 8'hC0;
  localparam logic [7:0] REQ_CODE_VENDOR = 8'h00;

  localparam logic [15:0] IDX_REVISION = 16'h0260;
  localparam logic [15:0] IDX_BUS_STATUS = 16'h0262;

  localparam logic [15:0] OFF_SERIAL_PORT_ON = 16'h0000;
  localparam logic [15:0] OFF_HANDSHAKE_CONFIG = 16'h0006;
  localparam logic [15:0] OFF_RESUME_CHARACTER = 16'h0007;
  localparam logic [15:0] OFF_PAUSE_CHARACTER = 16'h0008;
  localparam logic [15:0] OFF_LINE_FAULT_FLAGS = 16'h0009;
  localparam logic [15:0] OFF_BREAK_LENGTH = 16'h000A;
  localparam logic [15:0] OFF_TURN_ON_DELAY = 16'h000B;
  localparam logic [15:0] OFF_PIN_FUNCTION_SELECT = 16'h000C;
  localparam logic [15:0] OFF_PIN_DIRECTION = 16'h000D;
  localparam logic [15:0] OFF_PIN_OUTPUT_RAISE = 16'h000E;
  localparam logic [15:0] OFF_PIN_OUTPUT_LOWER = 16'h000F;
  localparam logic [15:0] OFF_PIN_LEVEL_READBACK = 16'h0010;
  localparam logic [15:0] OFF_PIN_EVENT_MASK = 16'h0011;
  localparam logic [15:0] OFF_CUSTOM_EVENT_CONTROL = 16'h0012;
  localparam logic [15:0] OFF_PIN_DRIVE_TYPE = 16'h0013;

  // Implemented bits of each register
  localparam logic [15:0] MASK_SERIAL_PORT_ON = 16'h0003;
  localparam logic [15:0] MASK_HANDSHAKE_CONFIG = 16'h000F;
  localparam logic [15:0] MASK_CHARACTER = 16'h00FF;
  localparam logic [15:0] MASK_LINE_FAULT_FLAGS = 16'h00F8;
  localparam logic [15:0] MASK_BREAK_LENGTH = 16'hFFFF;
  localparam logic [15:0] MASK_TURN_ON_DELAY = 16'h000F;
  localparam logic [15:0] MASK_PIN_TEN = 16'h03FF;
  localparam logic [15:0] MASK_PIN_LEVEL_READBACK = 16'h0FFF;
  localparam logic [15:0] MASK_PIN_EVENT_MASK = 16'h07FF;
  localparam logic [15:0] MASK_CUSTOM_EVENT_CONTROL = 16'h0003;
  localparam logic [15:0] MASK_PIN_DRIVE_TYPE = 16'h0BFF;
  localparam logic [15:0] MASK_BUS_STATUS = 16'hFFFF;

  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam int FAULT_LSB = 3;
  localparam int PIN_COUNT = 10;
  localparam int LEVEL_COUNT = 12;

  typedef struct packed {
    logic [7:0] reqType;
    logic [7:0] reqCode;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
  } uub_setup_t;

  typedef struct packed {
    logic valid;
    logic stall;
    logic [15:0] data;
  } uub_answer_t;

  typedef struct packed {
    logic [15:0] serialPortOn;
    logic [15:0] handshakeConfig;
    logic [15:0] resumeCharacter;
    logic [15:0] pauseCharacter;
    logic [15:0] breakLength;
    logic [15:0] turnOnDelay;
    logic [15:0] pinFunctionSelect;
    logic [15:0] pinDirection;
    logic [15:0] pinEventMask;
    logic [15:0] customEventControl;
    logic [15:0] pinDriveType;
    logic [15:0] busStatus;
  } uub_cfg_t;

endpackage

//--- verilog/uub_pin_output_latch.sv
// Purpose: Output level latch driven by raise and lower strobes
// Assumes: Strobes are one-cycle pulses from the register bank
// Notes: Raise wins when both strobes name the same bit
`timescale 1ns/100ps
module uub_pin_output_latch
  import uub_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire logic rst, // Synchronous reset
  input wire logic raiseStrobe, // Raise write pulse
  input wire logic lowerStrobe, // Lower write pulse
  input wire logic [PIN_COUNT-1:0] bits, // Bits named by the write
  output logic [PIN_COUNT-1:0] level // Latched output levels
);

  logic [PIN_COUNT-1:0] raiseBits;
  logic [PIN_COUNT-1:0] lowerBits;

  assign raiseBits = raiseStrobe ? bits : '0;
  assign lowerBits = lowerStrobe ? bits : '0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      level <= '0;
    end else begin
      level <= (level & ~lowerBits) | raiseBits;
    end
  end

endmodule

//--- verilog/uub_register_bank.sv
// Purpose: 16-bit register bank reached by vendor control requests
// Assumes: Setup fields arrive decoded, one request per reqValid pulse
// Notes: Answers come one cycle after the request, from flip-flops
`timescale 1ns/100ps
module uub_register_bank
  import uub_pkg::*;
#(
  parameter logic [15:0] SILICON_REVISION = 16'h0A5C // Arbitrary value
) (
  input wire logic core_clk, // Core clock, 200 MHz
  input wire logic rst, // Synchronous reset, bus reset
  input wire logic reqValid, // Setup request present, one cycle
  input wire uub_setup_t setup, // Decoded setup fields
  input wire logic [4:0] faultEvents, // Line fault pulses, same clock
  input wire logic [LEVEL_COUNT-1:0] pinLevelsIn, // Pin levels, async
  output uub_answer_t answer, // Request answer
  output uub_cfg_t cfg, // Register contents
  output logic [PIN_COUNT-1:0] pinOutLevel // Latched pin output levels
);

  logic genWrite;
  logic genRead;
  logic revRead;
  logic statWrite;
  logic statRead;
  logic isVendor;
  logic [15:0] wMask;
  logic [15:0] rMask;
  logic [15:0] readWord;
  logic [15:0] faultFlags;
  logic [LEVEL_COUNT-1:0] levelMeta;
  logic [LEVEL_COUNT-1:0] levelSync;
  logic raiseStrobe;
  logic lowerStrobe;

  // Writable bits per address, zero for unmapped or read-only
  function automatic logic [15:0] writeMask(input logic [15:0] addr);
    case (addr)
      OFF_SERIAL_PORT_ON: writeMask = MASK_SERIAL_PORT_ON;
      OFF_HANDSHAKE_CONFIG: writeMask = MASK_HANDSHAKE_CONFIG;
      OFF_RESUME_CHARACTER: writeMask = MASK_CHARACTER;
      OFF_PAUSE_CHARACTER: writeMask = MASK_CHARACTER;
      OFF_LINE_FAULT_FLAGS: writeMask = MASK_LINE_FAULT_FLAGS;
      OFF_BREAK_LENGTH: writeMask = MASK_BREAK_LENGTH;
      OFF_TURN_ON_DELAY: writeMask = MASK_TURN_ON_DELAY;
      OFF_PIN_FUNCTION_SELECT: writeMask = MASK_PIN_TEN;
      OFF_PIN_DIRECTION: writeMask = MASK_PIN_TEN;
      OFF_PIN_OUTPUT_RAISE: writeMask = MASK_PIN_TEN;
      OFF_PIN_OUTPUT_LOWER: writeMask = MASK_PIN_TEN;
      OFF_PIN_EVENT_MASK: writeMask = MASK_PIN_EVENT_MASK;
      OFF_CUSTOM_EVENT_CONTROL: writeMask = MASK_CUSTOM_EVENT_CONTROL;
      OFF_PIN_DRIVE_TYPE: writeMask = MASK_PIN_DRIVE_TYPE;
      default: writeMask = RESET_WORD;
    endcase
  endfunction

  // Readable bits per address; write-only registers read as zero
  function automatic logic [15:0] readMask(input logic [15:0] addr);
    case (addr)
      OFF_PIN_OUTPUT_RAISE: readMask = RESET_WORD;
      OFF_PIN_OUTPUT_LOWER: readMask = RESET_WORD;
      OFF_PIN_LEVEL_READBACK: readMask = MASK_PIN_LEVEL_READBACK;
      default: readMask = writeMask(addr);
    endcase
  endfunction

  function automatic logic isMapped(input logic [15:0] addr);
    isMapped = (writeMask(addr) != RESET_WORD) || (addr == OFF_PIN_LEVEL_READBACK);
  endfunction

  assign isVendor = reqValid && (setup.reqCode == REQ_CODE_VENDOR) &&
                    (setup.reqType == REQ_TYPE_REG_WRITE || setup.reqType == REQ_TYPE_REG_READ ||
                     setup.reqType == REQ_TYPE_DEV_WRITE || setup.reqType == REQ_TYPE_DEV_READ);
  // Generic register commands
  // Read-only and unmapped addresses refuse writes
  assign genWrite = isVendor && setup.reqType == REQ_TYPE_REG_WRITE && (wMask != RESET_WORD);
  assign genRead = isVendor && setup.reqType == REQ_TYPE_REG_READ && isMapped(setup.index);
  assign revRead = isVendor && setup.reqType == REQ_TYPE_DEV_READ && setup.index == IDX_REVISION;
  assign statRead = isVendor && setup.reqType == REQ_TYPE_DEV_READ &&
                    setup.index == IDX_BUS_STATUS;
  assign statWrite = isVendor && setup.reqType == REQ_TYPE_DEV_WRITE &&
                     setup.index == IDX_BUS_STATUS;

  assign wMask = writeMask(setup.index);
  assign rMask = readMask(setup.index);
  assign raiseStrobe = genWrite && setup.index == OFF_PIN_OUTPUT_RAISE;
  assign lowerStrobe = genWrite && setup.index == OFF_PIN_OUTPUT_LOWER;

  // Pin level synchroniser
  always_ff @(posedge core_clk) begin
    if (rst) begin
      levelMeta <= '0;
      levelSync <= '0;
    end else begin
      levelMeta <= pinLevelsIn;
      levelSync <= levelMeta;
    end
  end

  // Sticky line faults; write one clears, a new event wins over the clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      faultFlags <= RESET_WORD;
    end else if (genWrite && setup.index == OFF_LINE_FAULT_FLAGS) begin
      faultFlags <= ((faultFlags & ~(setup.value & MASK_LINE_FAULT_FLAGS)) |
                    (16'(faultEvents) << FAULT_LSB)) & MASK_LINE_FAULT_FLAGS;
    end else begin
      faultFlags <= (faultFlags | (16'(faultEvents) << FAULT_LSB)) & MASK_LINE_FAULT_FLAGS;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg <= '0;
    end else if (statWrite) begin
      cfg.busStatus <= setup.value & MASK_BUS_STATUS;
    end else if (genWrite) begin
      case (setup.index)
        OFF_SERIAL_PORT_ON: cfg.serialPortOn <= setup.value & wMask;
        OFF_HANDSHAKE_CONFIG: cfg.handshakeConfig <= setup.value & wMask;
        OFF_RESUME_CHARACTER: cfg.resumeCharacter <= setup.value & wMask;
        OFF_PAUSE_CHARACTER: cfg.pauseCharacter <= setup.value & wMask;
        OFF_BREAK_LENGTH: cfg.breakLength <= setup.value & wMask;
        OFF_TURN_ON_DELAY: cfg.turnOnDelay <= setup.value & wMask;
        OFF_PIN_FUNCTION_SELECT: cfg.pinFunctionSelect <= setup.value & wMask;
        OFF_PIN_DIRECTION: cfg.pinDirection <= setup.value & wMask;
        OFF_PIN_EVENT_MASK: cfg.pinEventMask <= setup.value & wMask;
        OFF_CUSTOM_EVENT_CONTROL: cfg.customEventControl <= setup.value & wMask;
        OFF_PIN_DRIVE_TYPE: cfg.pinDriveType <= setup.value & wMask;
        default: cfg.busStatus <= cfg.busStatus;
      endcase
    end
  end

  always_comb begin
    case (setup.index)
      OFF_SERIAL_PORT_ON: readWord = cfg.serialPortOn;
      OFF_HANDSHAKE_CONFIG: readWord = cfg.handshakeConfig;
      OFF_RESUME_CHARACTER: readWord = cfg.resumeCharacter;
      OFF_PAUSE_CHARACTER: readWord = cfg.pauseCharacter;
      OFF_LINE_FAULT_FLAGS: readWord = faultFlags;
      OFF_BREAK_LENGTH: readWord = cfg.breakLength;
      OFF_TURN_ON_DELAY: readWord = cfg.turnOnDelay;
      OFF_PIN_FUNCTION_SELECT: readWord = cfg.pinFunctionSelect;
      OFF_PIN_DIRECTION: readWord = cfg.pinDirection;
      OFF_PIN_LEVEL_READBACK: readWord = 16'(levelSync);
      OFF_PIN_EVENT_MASK: readWord = cfg.pinEventMask;
      OFF_CUSTOM_EVENT_CONTROL: readWord = cfg.customEventControl;
      OFF_PIN_DRIVE_TYPE: readWord = cfg.pinDriveType;
      default: readWord = RESET_WORD;
    endcase
  end

  // Answer: data for reads, empty ack for writes, stall for bad vendor requests
  always_ff @(posedge core_clk) begin
    if (rst) begin
      answer <= '0;
    end else begin
      answer.valid <= isVendor;
      answer.stall <= isVendor && !(genWrite || genRead || revRead || statRead || statWrite);
      if (revRead) begin
        answer.data <= SILICON_REVISION;
      end else if (statRead) begin
        answer.data <= cfg.busStatus;
      end else if (genRead) begin
        answer.data <= readWord & rMask;
      end else begin
        answer.data <= RESET_WORD;
      end
    end
  end

  uub_pin_output_latch outLatch (
    .core_clk(core_clk),
    .rst(rst),
    .raiseStrobe(raiseStrobe),
    .lowerStrobe(lowerStrobe),
    .bits(setup.value[PIN_COUNT-1:0]),
    .level(pinOutLevel)
  );

  // Helper: read mask of the last vendor request, all ones unless it was a generic read
  logic [15:0] lastMask;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lastMask <= RESET_WORD;
    end else if (isVendor) begin
      lastMask <= genRead ? rMask : 16'hFFFF;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  answer_timing_a: assert property (isVendor |=> answer.valid)
    else $error("Vendor request not answered next cycle");
  answer_quiet_a: assert property (!isVendor |=> !answer.valid)
    else $error("Answer without a vendor request");
  port_write_a: assert property (genWrite && setup.index == OFF_SERIAL_PORT_ON |=>
    cfg.serialPortOn == ($past(setup.value) & MASK_SERIAL_PORT_ON))
    else $error("Serial port register not written");
  rev_generic_a: assert property (reqValid && setup.reqType == REQ_TYPE_REG_READ &&
    setup.reqCode == REQ_CODE_VENDOR && setup.index == IDX_REVISION |=> answer.stall)
    else $error("Revision reached by generic read");
  rev_read_a: assert property (revRead |=> !answer.stall && answer.data == SILICON_REVISION)
    else $error("Revision read wrong");
  word_write_a: assert property (genWrite && setup.index == OFF_BREAK_LENGTH |=>
    cfg.breakLength == $past(setup.value))
    else $error("Break length not stored as full word");
  reserved_store_a: assert property ((cfg.pinDriveType & ~MASK_PIN_DRIVE_TYPE) == 16'h0000 &&
    (cfg.resumeCharacter & ~MASK_CHARACTER) == 16'h0000)
    else $error("Reserved bit stored");
  reserved_read_a: assert property (answer.valid && !answer.stall |->
    (answer.data & ~lastMask) == 16'h0000)
    else $error("Reserved bit read nonzero");
  stat_trip_a: assert property (statWrite ##2 statRead |=>
    answer.data == $past(setup.value, 3))
    else $error("Bus status round trip failed");

  write_seen_c: cover property (genWrite ##2 genRead);
  stall_seen_c: cover property (answer.valid && answer.stall);
  raise_lower_c: cover property (raiseStrobe ##[1:4] lowerStrobe);

endmodule

//--- sim/uub_host_model.sv
// Purpose: Host model issuing vendor register requests
// Assumes: Answer is registered on the taking edge and read at the next falling edge
// Notes: Setup lines are inverted once the request is over
`timescale 1ns/100ps
module uub_host_model
  import uub_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire uub_answer_t answer, // Device answer
  output logic reqValid, // Request strobe
  output uub_setup_t setup // Request fields
);
  initial begin
    reqValid = 1'b0;
    setup = '0;
  end
  // Address in index, data in value
  task automatic xfer(input logic [7:0] t, input logic [15:0] idx,
      input logic [15:0] val, output logic [15:0] rd, output logic st,
      output logic vl);
    @(negedge core_clk);
    reqValid = 1'b1;
    setup = '{t, REQ_CODE_VENDOR, val, idx, t[7] ? 16'h0002 : 16'h0000};
    @(negedge core_clk);
    reqValid = 1'b0;
    setup = ~setup;
    rd = answer.data;
    st = answer.stall;
    vl = answer.valid;
  endtask
endmodule

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the register bank
// Assumes: Inputs change on the falling clock edge
// Notes: Each scenario is one task
`timescale 1ns/100ps
module tb_top
  import uub_pkg::*;
;
  localparam logic [15:0] REV = 16'h1E3D; // Arbitrary value
  localparam logic [15:0] OFFS [11] = '{16'h0006, 16'h0007, 16'h0008,
    16'h000A, 16'h000B, 16'h000C, 16'h000D, 16'h0011, 16'h0012, 16'h0013, 16'h0000};
  localparam logic [15:0] MSKS [11] = '{16'h000F, 16'h00FF, 16'h00FF,
    16'hFFFF, 16'h000F, 16'h03FF, 16'h03FF, 16'h07FF, 16'h0003, 16'h0BFF, 16'h0003};
  logic core_clk, rst, reqValid, st, vl;
  uub_setup_t setup;
  logic [4:0] faultEvents;
  logic [LEVEL_COUNT-1:0] pinLevelsIn;
  uub_answer_t answer;
  uub_cfg_t cfg;
  logic [PIN_COUNT-1:0] pinOutLevel;
  logic [15:0] rd;
  int nMismatch, checksDone;
  uub_register_bank #(.SILICON_REVISION(REV)) uub_register_bank_i (
    .core_clk(core_clk), .rst(rst), .reqValid(reqValid), .setup(setup),
    .faultEvents(faultEvents), .pinLevelsIn(pinLevelsIn), .answer(answer),
    .cfg(cfg), .pinOutLevel(pinOutLevel));
  uub_host_model uub_host_model_i (.core_clk(core_clk), .answer(answer),
    .reqValid(reqValid), .setup(setup));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rq(input logic [7:0] t, input logic [15:0] idx, input logic [15:0] val);
    uub_host_model_i.xfer(t, idx, val, rd, st, vl);
    chk({15'h0, vl}, 16'h0001);
  endtask
  task automatic t_reset();
    foreach (OFFS[i]) begin
      rq(REQ_TYPE_REG_READ, OFFS[i], 16'h0);
      chk(rd, RESET_WORD);
    end
    rq(REQ_TYPE_REG_READ, OFF_LINE_FAULT_FLAGS, 16'h0);
    chk(rd, RESET_WORD);
  endtask
  task automatic t_rw();
    // Port off before writes, on again last
    rq(REQ_TYPE_REG_WRITE, OFF_SERIAL_PORT_ON, 16'h0000);
    foreach (OFFS[i]) begin
      rq(REQ_TYPE_REG_WRITE, OFFS[i], 16'hFFFF);
      chk({15'h0, st}, 16'h0000);
      rq(REQ_TYPE_REG_READ, OFFS[i], 16'h0);
      chk(rd, MSKS[i]);
    end
    chk(cfg.serialPortOn, 16'h0003);
    chk(cfg.breakLength, 16'hFFFF);
    chk(cfg.pinDriveType, 16'h0BFF);
  endtask
  task automatic t_dedicated();
    rq(REQ_TYPE_DEV_READ, IDX_REVISION, 16'h0);
    chk(rd, REV);
    rq(REQ_TYPE_REG_READ, IDX_REVISION, 16'h0);
    chk({15'h0, st}, 16'h0001);
    rq(REQ_TYPE_REG_WRITE, IDX_BUS_STATUS, 16'h1234);
    chk({15'h0, st}, 16'h0001);
    rq(REQ_TYPE_DEV_WRITE, OFF_SERIAL_PORT_ON, 16'h0);
    chk({15'h0, st}, 16'h0001);
    rq(REQ_TYPE_DEV_WRITE, IDX_BUS_STATUS, 16'h1234);
    rq(REQ_TYPE_DEV_READ, IDX_BUS_STATUS, 16'h0);
    chk(rd, 16'h1234);
    chk(cfg.busStatus, 16'h1234);
  endtask
  task automatic t_pins();
    rq(REQ_TYPE_REG_WRITE, OFF_PIN_OUTPUT_RAISE, 16'h0205);
    @(negedge core_clk);
    chk({6'h0, pinOutLevel}, 16'h0205);
    rq(REQ_TYPE_REG_WRITE, OFF_PIN_OUTPUT_LOWER, 16'h0201);
    @(negedge core_clk);
    chk({6'h0, pinOutLevel}, 16'h0004);
    rq(REQ_TYPE_REG_READ, OFF_PIN_OUTPUT_RAISE, 16'h0);
    chk(rd, 16'h0000);
  endtask
  task automatic t_faults();
    @(negedge core_clk);
    faultEvents = 5'b10001;
    @(negedge core_clk);
    faultEvents = 5'b00000;
    rq(REQ_TYPE_REG_READ, OFF_LINE_FAULT_FLAGS, 16'h0);
    chk(rd, 16'h0088);
    rq(REQ_TYPE_REG_WRITE, OFF_LINE_FAULT_FLAGS, 16'h0008);
    rq(REQ_TYPE_REG_READ, OFF_LINE_FAULT_FLAGS, 16'h0);
    chk(rd, 16'h0080);
    // Event held over the clearing write: set must win
    faultEvents = 5'b00001;
    rq(REQ_TYPE_REG_WRITE, OFF_LINE_FAULT_FLAGS, 16'h0008);
    faultEvents = 5'b00000;
    rq(REQ_TYPE_REG_READ, OFF_LINE_FAULT_FLAGS, 16'h0);
    chk(rd, 16'h0088);
  endtask
  task automatic t_midreset();
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    chk({6'h0, pinOutLevel}, 16'h0000);
    chk(cfg.breakLength, RESET_WORD);
    rq(REQ_TYPE_REG_READ, OFF_LINE_FAULT_FLAGS, 16'h0);
    chk(rd, RESET_WORD);
    rq(REQ_TYPE_REG_READ, OFF_BREAK_LENGTH, 16'h0);
    chk(rd, RESET_WORD);
    rq(REQ_TYPE_REG_WRITE, OFF_BREAK_LENGTH, 16'h1234);
    rq(REQ_TYPE_REG_READ, OFF_BREAK_LENGTH, 16'h0);
    chk(rd, 16'h1234);
  endtask
  task automatic t_levels();
    pinLevelsIn = 12'hABC;
    repeat (3) @(negedge core_clk);
    rq(REQ_TYPE_REG_READ, OFF_PIN_LEVEL_READBACK, 16'h0);
    chk(rd, 16'h0ABC);
    rq(REQ_TYPE_REG_WRITE, OFF_PIN_LEVEL_READBACK, 16'h0001);
    chk({15'h0, st}, 16'h0001);
    rq(REQ_TYPE_REG_READ, 16'h0001, 16'h0);
    chk({15'h0, st}, 16'h0001);
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    nMismatch++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    faultEvents = 5'b00000;
    pinLevelsIn = '0;
    nMismatch = 0;
    checksDone = 0;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_rw();
    t_dedicated();
    t_pins();
    t_faults();
    t_levels();
    t_midreset();
    wrap_up();
  end
endmodule
